// ### design/snl_top.sv
// Single-wire nibble link controller with AHB-Lite register access
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.

// Behaviour
// - Transmit tick lasts tick divisor plus one prescaled clock periods.
// - An enabled pause never lasts fewer than 12 ticks.
// - Async frame length sets frame period; values above 2047 act as 2047.
// - Direction bit 11 set selects receiver, clear selects transmitter.
// - Trigger mode sends on frame-go only; otherwise frames back to back.
// - Idle-level bit set rests line low, clear rests high; transmit only.
// - Receive with CRC bit set checks CRC nibble; clear means no check.
// - Transmit with CRC bit set computes CRC; clear sends software value.
// - Pause bit adds a pause after CRC, or expects one when receiving.
// - Receive mode short-PWM bit enables external frame requests.
// - Prescaler bit 4 divides clock by four or one for all timing.
// - Halt-in-idle stops the module while the device idles.
// - Enable bit 15 switches module on; resets to zero.
// - Receiver times falling-edge intervals; sync must lie within limits.
// - Valid sync is captured and sets tick time for the frame.
// - Following intervals must be valid nibbles; stored into buffers.
// - Frame completion raises an event; software reads buffer in time.
// - Nibble lasts value plus 12 ticks; sync lasts 56 ticks.
// - Nibble count codes 1 to 6 select data nibbles; 0 and 7 reserved.
// - Frame-go set by software, held during frame, cleared at end.
// - Receive nibble under 12 or over 27 ticks flags framing fault.
module snl_top #(
   parameter logic [5:0] SPC_TICKS = 6'h05
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata_q,
   output logic             hreadyout_q,
   output logic             hresp_q,
   input  wire logic        link_in,
   output logic             link_out_q,
   output logic             link_oe_q,
   input  wire logic        device_idle,
   input  wire logic        spc_request,
   output logic             frame_event_q
);
   logic [15:0]         ctrl_q, tickup_q, frmlow_q, sync_cap_q;
   logic [31:0]         buf_q;
   logic                go_q, frm_fault_q, chk_fault_q, rx_idle_q;
   snl_pkg::snl_aphase_t ap_q;
   logic [1:0]          div_q;
   logic [15:0]         tdiv_q, intv_q;
   logic                run, pre_tick, tick, is_rx, wr_go;
   snl_pkg::snl_tx_st_t tx_st_q;
   snl_pkg::snl_rx_st_t rx_st_q;
   logic [2:0]          nib_q, rx_idx_q, n_cfg;
   logic [10:0]         seg_q, elap_q, seg_len, frame_eff, pause_len;
   logic [3:0]          cur_nib, crc_now;
   logic                seg_end, in_prev_q, fall;
   logic [5:0]          rx_ticks, spc_q;
   logic [15:0]         rdata;

   function automatic logic [2:0] nib_count(input logic [2:0] code);
      if (code < snl_pkg::NIB_FIRST) return snl_pkg::NIB_FIRST;
      if (code > snl_pkg::NIB_LAST)  return snl_pkg::NIB_LAST;
      return code;
   endfunction : nib_count

   // Nibble k of the frame word: status first, CRC always in bits 3:0
   function automatic logic [3:0] nib_get(input logic [31:0] w,
                                         input logic [2:0]  k);
      return w[5'(31 - 4 * int'(k)) -: 4];
   endfunction : nib_get

   function automatic logic [3:0] crc_step(input logic [3:0] c,
                                          input logic [3:0] d);
      return d ^ snl_pkg::CRC_TABLE[6'(4 * int'(c)) +: 4];
   endfunction : crc_step

   // Seed 5, data nibbles only, then one zero nibble of augmentation
   function automatic logic [3:0] crc_of(input logic [31:0] w,
                                        input logic [2:0]  n);
      logic [3:0] c;
      c = snl_pkg::CRC_SEED;
      for (int k = 1; k <= 6; k++) begin
         if (3'(k) <= n) begin
            c = crc_step(c, nib_get(w, 3'(k)));
         end
      end
      return crc_step(c, snl_pkg::NIB_ZERO);
   endfunction : crc_of

   // Round interval * 56 / sync to whole ticks without a divider
   function automatic logic [5:0] to_ticks(input logic [15:0] iv,
                                          input logic [15:0] sy);
      logic [31:0] lhs;
      logic [5:0]  n;
      lhs = 32'(iv) * 32'(2 * int'(snl_pkg::SYNC_TICKS));
      n   = '0;
      for (int k = 1; k <= int'(snl_pkg::TICK_MAX); k++) begin
         if (lhs >= 32'(sy) * 32'(2 * k - 1)) begin
            n = 6'(k);
         end
      end
      return n;
   endfunction : to_ticks

   assign is_rx     = ctrl_q[snl_pkg::CB_RX];
   assign run       = ctrl_q[snl_pkg::CB_ON] &&
                      !(ctrl_q[snl_pkg::CB_HALT] && device_idle);
   assign pre_tick  = !ctrl_q[snl_pkg::CB_DIV] ||
                      (div_q == snl_pkg::DIV4_LAST);
   assign tick      = run && !is_rx && pre_tick &&
                      (tdiv_q == tickup_q);
   assign n_cfg     = nib_count(ctrl_q[2:0]);
   assign crc_now   = crc_of(buf_q, n_cfg);
   assign frame_eff = (frmlow_q > snl_pkg::FRAME_MAX) ?
                      11'(snl_pkg::FRAME_MAX) : frmlow_q[10:0];
   // Outside trigger mode the pause fills the frame up to its length, but never below the minimum;
   // elap_q keeps running in the pause, so take off the pause ticks so far
   assign pause_len = (!ctrl_q[snl_pkg::CB_TRIG] &&
                       frame_eff >= elap_q - seg_q + snl_pkg::PAUSE_MIN) ?
                      frame_eff - (elap_q - seg_q) :
                      snl_pkg::PAUSE_MIN;
   assign cur_nib   = (tx_st_q == snl_pkg::TX_CRC) ?
                      (ctrl_q[snl_pkg::CB_CRC] ? crc_now : buf_q[3:0]) :
                      nib_get(buf_q, nib_q);

   always_comb begin
      unique case (tx_st_q)
         snl_pkg::TX_SYNC:  seg_len = 11'(snl_pkg::SYNC_TICKS);
         snl_pkg::TX_PAUSE: seg_len = pause_len;
         default:           seg_len = 11'(snl_pkg::NIB_MIN) + 11'(cur_nib);
      endcase
   end
   assign seg_end = tick && (seg_q + 11'h001 >= seg_len);

   // Prescaler and tick divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q  <= '0;
         tdiv_q <= '0;
      end else begin
         // Restart the tick phase while idle so the sync pulse is whole
         div_q <= (run && (is_rx || tx_st_q != snl_pkg::TX_IDLE)) ?
                  div_q + 2'h1 : '0;
         if (!run || is_rx || tick || tx_st_q == snl_pkg::TX_IDLE) begin
            tdiv_q <= '0;
         end else if (pre_tick) begin
            tdiv_q <= tdiv_q + 16'h0001;
         end
      end
   end

   // AHB-Lite slave: writes zero wait, reads one wait state
   assign wr_go = ap_q.valid && ap_q.write && ap_q.addr == snl_pkg::ADDR_STATUS;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q        <= '0;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         hrdata_q    <= '0;
      end else begin
         hresp_q <= 1'b0;
         if (!hreadyout_q) begin
            hreadyout_q <= 1'b1;
            hrdata_q    <= {16'h0000, rdata};
         end
         if (hready) begin
            ap_q.valid <= hsel && htrans[1];
            ap_q.write <= hwrite;
            ap_q.addr  <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
               hreadyout_q <= 1'b0;
            end
         end
      end
   end

   always_comb begin
      unique case (ap_q.addr)
         snl_pkg::ADDR_CTRL:    rdata = ctrl_q;
         snl_pkg::ADDR_TICKUP:  rdata = tickup_q;
         snl_pkg::ADDR_FRMLOW:  rdata = frmlow_q;
         snl_pkg::ADDR_STATUS:  rdata = {8'h00,
            (tx_st_q == snl_pkg::TX_PAUSE) || (rx_st_q == snl_pkg::RX_PAUSE),
            is_rx ? rx_idx_q : ((tx_st_q == snl_pkg::TX_CRC) ?
               snl_pkg::NIB_CRC : ((tx_st_q == snl_pkg::TX_NIB) ? nib_q : 3'h0)),
            chk_fault_q, frm_fault_q, rx_idle_q,
            (!is_rx && !ctrl_q[snl_pkg::CB_TRIG]) ?
               ctrl_q[snl_pkg::CB_ON] : go_q};
         snl_pkg::ADDR_BUF_HI:  rdata = buf_q[31:16];
         snl_pkg::ADDR_BUF_LO:  rdata = buf_q[15:0];
         snl_pkg::ADDR_SYNCCAP: rdata = sync_cap_q;
         default:               rdata = '0;
      endcase
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q   <= snl_pkg::REG_RESET;
         tickup_q <= snl_pkg::REG_RESET;
         frmlow_q <= snl_pkg::REG_RESET;
      end else if (ap_q.valid && ap_q.write) begin
         unique case (ap_q.addr)
            snl_pkg::ADDR_CTRL:   ctrl_q   <= hwdata[15:0] & snl_pkg::CTRL_MASK;
            snl_pkg::ADDR_TICKUP: tickup_q <= hwdata[15:0];
            snl_pkg::ADDR_FRMLOW: frmlow_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Transmit sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_q <= snl_pkg::TX_IDLE;
         nib_q   <= '0;
         seg_q   <= '0;
         elap_q  <= '0;
      end else if (!run || is_rx) begin
         tx_st_q <= snl_pkg::TX_IDLE;
         seg_q   <= '0;
      end else if (tx_st_q == snl_pkg::TX_IDLE) begin
         nib_q  <= '0;
         seg_q  <= '0;
         elap_q <= '0;
         if (!ctrl_q[snl_pkg::CB_TRIG] || go_q) begin
            tx_st_q <= snl_pkg::TX_SYNC;
         end
      end else if (tick) begin
         seg_q  <= seg_end ? '0 : seg_q + 11'h001;
         elap_q <= (elap_q < 11'(snl_pkg::FRAME_MAX)) ?
                   elap_q + 11'h001 : elap_q;
         if (seg_end) begin
            unique case (tx_st_q)
               snl_pkg::TX_SYNC: tx_st_q <= snl_pkg::TX_NIB;
               snl_pkg::TX_NIB: begin
                  if (nib_q == n_cfg) begin
                     tx_st_q <= snl_pkg::TX_CRC;
                  end
                  nib_q <= nib_q + 3'h1;
               end
               snl_pkg::TX_CRC: tx_st_q <= ctrl_q[snl_pkg::CB_PAUSE] ?
                                snl_pkg::TX_PAUSE : snl_pkg::TX_IDLE;
               default: tx_st_q <= snl_pkg::TX_IDLE;
            endcase
         end
      end
   end

   // Frame-go: hardware clears at frame end, a software set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         go_q <= 1'b0;
      end else if (wr_go && hwdata[snl_pkg::SB_GO] && !is_rx &&
                   ctrl_q[snl_pkg::CB_TRIG]) begin
         go_q <= 1'b1;
      end else if (is_rx) begin
         go_q <= (rx_st_q == snl_pkg::RX_DATA);
      end else if (!ctrl_q[snl_pkg::CB_ON] || (seg_end &&
                   (tx_st_q == snl_pkg::TX_PAUSE ||
                    (tx_st_q == snl_pkg::TX_CRC &&
                     !ctrl_q[snl_pkg::CB_PAUSE])))) begin
         go_q <= 1'b0;
      end
   end

   // Line driver: low pulse opens each segment, level set by polarity
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_out_q <= 1'b1;
         link_oe_q  <= 1'b0;
         spc_q      <= '0;
      end else if (is_rx) begin
         link_out_q <= 1'b0;
         link_oe_q  <= spc_q != '0;
         if (run && ctrl_q[snl_pkg::CB_SPC] && spc_request &&
             rx_st_q == snl_pkg::RX_HUNT && spc_q == '0) begin
            spc_q <= SPC_TICKS;
         end else if (spc_q != '0 && pre_tick) begin
            spc_q <= spc_q - 6'h01;
         end
      end else begin
         spc_q      <= '0;
         link_oe_q  <= ctrl_q[snl_pkg::CB_ON];
         link_out_q <= ctrl_q[snl_pkg::CB_INV] ^
            !(tx_st_q != snl_pkg::TX_IDLE &&
              seg_q < 11'(snl_pkg::LOW_TICKS));
      end
   end

   // Receive interval timer on the prescaled clock
   assign fall     = in_prev_q && !link_in;
   assign rx_ticks = to_ticks(intv_q, sync_cap_q);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_prev_q <= 1'b1;
         intv_q    <= '0;
         rx_idle_q <= 1'b0;
      end else begin
         in_prev_q <= link_in;
         if (!run || !is_rx) begin
            intv_q <= '0;
         end else if (fall) begin
            // The edge cycle itself belongs to the new interval
            intv_q <= pre_tick ? 16'h0001 : '0;
         end else if (pre_tick && intv_q != '1) begin
            intv_q <= intv_q + 16'h0001;
         end
         rx_idle_q <= run && is_rx && link_in && intv_q >= tickup_q;
      end
   end

   // Receive decoder
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_q       <= snl_pkg::RX_HUNT;
         rx_idx_q      <= '0;
         sync_cap_q    <= '0;
         buf_q         <= '0;
         frm_fault_q   <= 1'b0;
         chk_fault_q   <= 1'b0;
         frame_event_q <= 1'b0;
      end else begin
         frame_event_q <= 1'b0;
         if (wr_go && !hwdata[snl_pkg::SB_FRM]) begin
            frm_fault_q <= 1'b0;
         end
         if (wr_go && !hwdata[snl_pkg::SB_CHK]) begin
            chk_fault_q <= 1'b0;
         end
         if (!is_rx && ap_q.valid && ap_q.write) begin
            if (ap_q.addr == snl_pkg::ADDR_BUF_HI) begin
               buf_q[31:16] <= hwdata[15:0];
            end else if (ap_q.addr == snl_pkg::ADDR_BUF_LO) begin
               buf_q[15:4] <= hwdata[15:4];
               if (!ctrl_q[snl_pkg::CB_CRC]) begin
                  buf_q[3:0] <= hwdata[3:0];
               end
            end
         end
         if (!is_rx && ctrl_q[snl_pkg::CB_CRC] && tx_st_q == snl_pkg::TX_CRC) begin
            buf_q[3:0] <= crc_now;
         end
         if (!is_rx && seg_end && tx_st_q == snl_pkg::TX_CRC) begin
            frame_event_q <= 1'b1;
         end
         if (!run || !is_rx) begin
            rx_st_q  <= snl_pkg::RX_HUNT;
            rx_idx_q <= '0;
         end else if (fall) begin
            unique case (rx_st_q)
               snl_pkg::RX_HUNT: begin
                  if (intv_q >= frmlow_q && intv_q <= tickup_q) begin
                     sync_cap_q <= intv_q;
                     rx_st_q    <= snl_pkg::RX_DATA;
                     rx_idx_q   <= '0;
                  end
               end
               snl_pkg::RX_DATA: begin
                  if (rx_ticks < snl_pkg::NIB_MIN ||
                      rx_ticks > snl_pkg::NIB_MAX) begin
                     frm_fault_q <= 1'b1;
                     rx_st_q     <= snl_pkg::RX_HUNT;
                  end else if (rx_idx_q == n_cfg + 3'h1) begin
                     buf_q[3:0]    <= 4'(rx_ticks - snl_pkg::NIB_MIN);
                     frame_event_q <= 1'b1;
                     if (ctrl_q[snl_pkg::CB_CRC] && crc_of(buf_q, n_cfg) !=
                         4'(rx_ticks - snl_pkg::NIB_MIN)) begin
                        chk_fault_q <= 1'b1;
                     end
                     rx_idx_q <= '0;
                     rx_st_q  <= ctrl_q[snl_pkg::CB_PAUSE] ?
                                 snl_pkg::RX_PAUSE : snl_pkg::RX_HUNT;
                  end else begin
                     buf_q[5'(31 - 4 * int'(rx_idx_q)) -: 4] <=
                        4'(rx_ticks - snl_pkg::NIB_MIN);
                     rx_idx_q <= rx_idx_q + 3'h1;
                  end
               end
               default: rx_st_q <= snl_pkg::RX_HUNT;
            endcase
         end
      end
   end

   // Checks
   logic [17:0] gap_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) gap_q <= '0;
      else gap_q <= (tick || tx_st_q == snl_pkg::TX_IDLE) ?
                    18'h00001 : gap_q + 18'h00001;
   end
   AST_TICK_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
      tick && $past(tick, 1) == 1'b0 && gap_q != 18'h00001 &&
      $stable(tickup_q) && !ctrl_q[snl_pkg::CB_DIV] && $past(run)
      |-> gap_q == 18'(tickup_q) + 18'h00001)
      else $error("tick spacing wrong");
   AST_PAUSE_MIN: assert property (@(posedge hclk) disable iff (!hresetn)
      seg_end && tx_st_q == snl_pkg::TX_PAUSE
      |-> seg_q + 11'h001 >= snl_pkg::PAUSE_MIN)
      else $error("pause too short");
   AST_FRAME_CAP: assert property (@(posedge hclk) disable iff (!hresetn)
      elap_q <= 11'(snl_pkg::FRAME_MAX))
      else $error("frame count past cap");
   AST_IDLE_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
      !is_rx && tx_st_q == snl_pkg::TX_IDLE
      |=> link_out_q == !$past(ctrl_q[snl_pkg::CB_INV]))
      else $error("idle level wrong");
   AST_DISABLE: assert property (@(posedge hclk) disable iff (!hresetn)
      !ctrl_q[snl_pkg::CB_ON] |=> tx_st_q == snl_pkg::TX_IDLE)
      else $error("frame not abandoned");
   AST_TRIG_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
      !is_rx && ctrl_q[snl_pkg::CB_TRIG] && !go_q &&
      tx_st_q == snl_pkg::TX_IDLE |=> tx_st_q == snl_pkg::TX_IDLE)
      else $error("frame without go");
   AST_GO_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      !is_rx && ctrl_q[snl_pkg::CB_TRIG] && ctrl_q[snl_pkg::CB_ON] &&
      go_q && tx_st_q inside {snl_pkg::TX_SYNC, snl_pkg::TX_NIB} &&
      $stable(ctrl_q) |=> go_q)
      else $error("go dropped mid frame");
   AST_FRM_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
      run && is_rx && fall && rx_st_q == snl_pkg::RX_DATA &&
      (rx_ticks < snl_pkg::NIB_MIN || rx_ticks > snl_pkg::NIB_MAX)
      |=> frm_fault_q && rx_st_q == snl_pkg::RX_HUNT)
      else $error("framing fault missed");
   AST_SYNC_CAP: assert property (@(posedge hclk) disable iff (!hresetn)
      run && is_rx && fall && rx_st_q == snl_pkg::RX_HUNT &&
      intv_q >= frmlow_q && intv_q <= tickup_q
      |=> sync_cap_q == $past(intv_q) && rx_st_q == snl_pkg::RX_DATA)
      else $error("sync not captured");
   AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
      hready && hsel && htrans[1] && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
      else $error("read wait state wrong");
   COV_TX_FRAME: cover property (@(posedge hclk) disable iff (!hresetn)
      !is_rx && frame_event_q);
   COV_RX_FRAME: cover property (@(posedge hclk) disable iff (!hresetn)
      is_rx && frame_event_q);
   COV_PAUSE: cover property (@(posedge hclk) disable iff (!hresetn)
      tx_st_q == snl_pkg::TX_PAUSE && seg_end);
   COV_CRC_FAULT: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(chk_fault_q));
endmodule : snl_top

// ### design/snl_pkg.sv
// Package: register map, field positions and frame constants of the link
package snl_pkg;
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_TICKUP  = 8'h04;
   localparam logic [7:0]  ADDR_FRMLOW  = 8'h08;
   localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
   localparam logic [7:0]  ADDR_BUF_HI  = 8'h10;
   localparam logic [7:0]  ADDR_BUF_LO  = 8'h14;
   localparam logic [7:0]  ADDR_SYNCCAP = 8'h18;
   localparam logic [15:0] CTRL_MASK    = 16'hAFD7;
   localparam logic [15:0] REG_RESET    = 16'h0000;
   localparam int CB_ON      = 15;
   localparam int CB_HALT    = 13;
   localparam int CB_RX      = 11;
   localparam int CB_TRIG    = 10;
   localparam int CB_INV     = 9;
   localparam int CB_CRC     = 8;
   localparam int CB_PAUSE   = 7;
   localparam int CB_SPC     = 6;
   localparam int CB_DIV     = 4;
   localparam int SB_PAUSE   = 7;
   localparam int SB_CHK     = 3;
   localparam int SB_FRM     = 2;
   localparam int SB_RXIDLE  = 1;
   localparam int SB_GO      = 0;
   localparam logic [1:0]  DIV4_LAST   = 2'h3;
   localparam logic [5:0]  SYNC_TICKS  = 6'h38;
   localparam logic [5:0]  NIB_MIN     = 6'h0C;
   localparam logic [5:0]  NIB_MAX     = 6'h1B;
   localparam logic [10:0] PAUSE_MIN   = 11'h00C;
   localparam logic [15:0] FRAME_MAX   = 16'h07FF;
   localparam logic [5:0]  LOW_TICKS   = 6'h05;
   localparam logic [2:0]  NIB_FIRST   = 3'h1;
   localparam logic [2:0]  NIB_LAST    = 3'h6;
   localparam logic [2:0]  NIB_CRC     = 3'h7;
   localparam logic [3:0]  CRC_SEED    = 4'h5;
   localparam logic [3:0]  NIB_ZERO    = 4'h0;
   localparam logic [63:0] CRC_TABLE   = 64'h582F_B6C1_4935_EA7D;
   localparam logic [5:0]  TICK_MAX    = 6'h1F;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } snl_aphase_t;

   typedef enum {TX_IDLE, TX_SYNC, TX_NIB, TX_CRC, TX_PAUSE} snl_tx_st_t;
   typedef enum {RX_HUNT, RX_DATA, RX_PAUSE} snl_rx_st_t;
endpackage : snl_pkg

// ### tb/snl_sensor.sv
// Remote sensor model: drives the wire with timed falling edges
module snl_sensor (
   input  wire logic hclk,
   output logic      line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line = 1'b1; // Pulled-up wire rests high when released
   // Short low pulse, then high; n is the fall-to-fall spacing in clocks
   task automatic seg(input int n);
      line <= 1'b0;
      repeat (10) @(posedge hclk);
      line <= 1'b1;
      repeat (n - 10) @(posedge hclk);
   endtask : seg
endmodule : snl_sensor

// ### tb/tb_top.sv
// Self-checking bench for the nibble link controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata_q, rd;
   logic        hreadyout_q, hresp_q, link_in, link_out_q, link_oe_q;
   logic        frame_event_q, device_idle = 0, spc_request = 0;
   int          n_errors = 0, num_checks = 0, n_evt = 0;
   always #10 hclk = ~hclk;
   always @(posedge hclk) if (frame_event_q === 1'b1) n_evt++;
   snl_top snl_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hready(hreadyout_q), .hwdata, .hrdata_q,
      .hreadyout_q, .hresp_q, .link_in, .link_out_q, .link_oe_q,
      .device_idle, .spc_request, .frame_event_q);
   snl_sensor snl_sensor_inst (.hclk, .line(link_in));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Single word transfer; the slave's ready decides every wait
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout_q !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout_q !== 1'b1);
      rd = hrdata_q;
   endtask : bus
   // Spacing of successive falling edges, in clocks
   task automatic edges(input int e[$]);
      time t0;
      @(negedge link_out_q);
      t0 = $time;
      foreach (e[i]) begin
         @(negedge link_out_q);
         chk(32'(($time - t0) / 20), e[i]);
         t0 = $time;
      end
   endtask : edges
   task automatic t_tx;
      bus(1'b0, snl_pkg::ADDR_CTRL, 0);
      chk({rd[15:0], 14'h0, link_oe_q, link_out_q}, 32'h1);
      bus(1'b1, snl_pkg::ADDR_TICKUP, 1);
      bus(1'b1, snl_pkg::ADDR_BUF_HI, 32'h3500);
      bus(1'b1, snl_pkg::ADDR_BUF_LO, 32'h0007);
      bus(1'b1, snl_pkg::ADDR_FRMLOW, 860);
      bus(1'b1, snl_pkg::ADDR_CTRL, 32'h8081);
      edges('{112, 30, 34, 38, 1507, 112});
      bus(1'b1, snl_pkg::ADDR_CTRL, 0);
      bus(1'b1, snl_pkg::ADDR_FRMLOW, 32'hFFFF);
      chk({link_oe_q, link_out_q}, 1);
      bus(1'b1, snl_pkg::ADDR_CTRL, 32'h8081);
      edges('{112, 30, 34, 38, 3881});
      $display("transmit timing test done");
   endtask : t_tx
   task automatic t_trig;
      bus(1'b1, snl_pkg::ADDR_CTRL, 0);
      bus(1'b1, snl_pkg::ADDR_CTRL, 32'h8681);
      repeat (2) @(posedge hclk);
      chk(link_out_q, 0);
      bus(1'b1, snl_pkg::ADDR_CTRL, 32'h8481);
      n_evt = 0;
      bus(1'b1, snl_pkg::ADDR_STATUS, 1);
      edges('{112, 30, 34, 38});
      bus(1'b0, snl_pkg::ADDR_STATUS, 0);
      chk({n_evt[3:0], rd[0]}, 5'h03);
      repeat (40) @(posedge hclk);
      bus(1'b0, snl_pkg::ADDR_STATUS, 0);
      chk({n_evt[3:0], rd[0]}, 5'h02);
      device_idle <= 1'b1;
      bus(1'b1, snl_pkg::ADDR_CTRL, 32'hA081);
      n_evt = 0;
      repeat (300) @(posedge hclk);
      chk(n_evt, 0);
      device_idle <= 1'b0;
      edges('{112});
      $display("triggered frame test done");
   endtask : t_trig
   task automatic t_rx;
      int s[$] = '{112, 36, 28, 50, 24};
      bus(1'b1, snl_pkg::ADDR_CTRL, 0);
      bus(1'b1, snl_pkg::ADDR_TICKUP, 134);
      bus(1'b1, snl_pkg::ADDR_FRMLOW, 90);
      bus(1'b1, snl_pkg::ADDR_CTRL, 32'h8801);
      n_evt = 0;
      foreach (s[i]) snl_sensor_inst.seg(s[i]);
      bus(1'b0, snl_pkg::ADDR_SYNCCAP, 0);
      chk(rd, 112);
      bus(1'b0, snl_pkg::ADDR_BUF_HI, 0);
      chk(rd[15:8], 8'h62);
      bus(1'b0, snl_pkg::ADDR_BUF_LO, 0);
      chk({n_evt[3:0], rd[3:0]}, 8'h1D);
      // Status nibble of 30 ticks is too long
      snl_sensor_inst.seg(112);
      snl_sensor_inst.seg(60);
      snl_sensor_inst.seg(30);
      bus(1'b0, snl_pkg::ADDR_STATUS, 0);
      chk(rd[2], 1);
      $display("receive test done");
   endtask : t_rx
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   // Longest run is the capped async frame, some 4100 clocks; about 7200 in all
   initial begin
      #400us;
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_tx();
      t_trig();
      t_rx();
      end_of_test();
   end
endmodule : tb_top
